// File: inc/borc_pkg.sv
// Package: offsets, field positions, reset values and codes of the routing config registers
`default_nettype none
package borc_pkg;

    localparam int          ADDR_W              = 9;
    localparam logic [8:0]  PULL_CFG_OFFSET     = 9'h145;
    localparam logic [8:0]  ROUTING_OFFSET      = 9'h146;
    localparam logic [8:0]  ROLE_TRIM_OFFSET    = 9'h147;
    localparam logic [8:0]  ALT_ADDR_OFFSET     = 9'h148;

    localparam int          PULL_IN0_BIT        = 0;
    localparam int          B_GOOD_LSB          = 6;
    localparam int          A_GOOD_LSB          = 4;
    localparam int          B_READY_LSB         = 2;
    localparam int          A_READY_LSB         = 0;
    localparam int          SOLO_BIT            = 7;
    localparam int          TRIM_LSB            = 0;
    localparam int          TRIM_W              = 3;
    localparam int          ALT_UPPER_LSB       = 4;
    localparam int          ALT_SEL_LSB         = 0;

    localparam logic [7:0]  PULL_CFG_RESET      = 8'h00;
    localparam logic [7:0]  ROUTING_RESET       = 8'h00;
    localparam logic [7:0]  ROLE_TRIM_RESET     = 8'h00;
    localparam logic [7:0]  ALT_ADDR_RESET      = 8'h00;
    // Writable bits; 0x148 bits 3:2 are read-only zero
    localparam logic [7:0]  ALT_ADDR_WMASK      = 8'hF3;

    localparam logic [1:0]  ROUTE_NONE          = 2'h0;
    localparam logic [1:0]  ROUTE_OUT_TWO       = 2'h1;
    localparam logic [1:0]  ROUTE_OUT_THREE     = 2'h2;

    localparam logic [1:0]  SEL_NONE            = 2'h0;
    localparam logic [1:0]  SEL_IN_ZERO         = 2'h1;
    localparam logic [1:0]  SEL_IN_ONE          = 2'h2;
    localparam logic [1:0]  SEL_IN_FOUR         = 2'h3;

    localparam logic [3:0]  UPPER_UNPROGRAMMED  = 4'h0;
    localparam logic [6:0]  ADDR_PAGE01_OFF     = 7'h00;
    localparam logic [6:0]  ADDR_PAGE23_OFF     = 7'h01;

    localparam int          OSC_NOMINAL_KHZ     = 6000;
    localparam int          OSC_STEP_KHZ        = 180;

endpackage
`default_nettype wire

// File: rtl/borc_regs.sv
// Routing, role, oscillator trim and second address configuration registers
`timescale 1ns/1ps
`default_nettype none
module borc_regs #(
    parameter logic [6:0] PRIMARY_BASE = 7'h68,  // Primary 7-bit base, arbitrary default
    parameter logic [6:0] DEFAULT_BASE = 7'h68   // Hardware default base, arbitrary default
) (
    input  wire logic       CLK,              // Core clock, 25 MHz
    input  wire logic       SYS_RST,          // Synchronous reset, active high
    input  wire logic       REG_WE,           // Register write strobe
    input  wire logic [8:0] REG_ADDR,         // Register address
    input  wire logic [7:0] REG_WDATA,        // Write data
    output logic      [7:0] REG_RDATA,        // Registered read data
    input  wire logic       RAIL_A_GOOD,      // Rail A power-good
    input  wire logic       RAIL_B_GOOD,      // Rail B power-good
    input  wire logic       RAIL_A_READY,     // Rail A ready
    input  wire logic       RAIL_B_READY,     // Rail B ready
    input  wire logic       GENERAL_INPUT_ZERO, // General input zero
    input  wire logic       GENERAL_INPUT_ONE,  // General input one
    input  wire logic       GENERAL_INPUT_FOUR, // General input four
    output logic            GENERAL_OUTPUT_TWO,   // Routed indications
    output logic            GENERAL_OUTPUT_THREE, // Routed indications
    output logic            INPUT_ZERO_PULLDOWN_EN, // Pull-down enable
    output logic            SOLO_ROLE_SELECT,  // 1 standalone, 0 companion
    output logic      [2:0] OSCILLATOR_TRIM,   // Trim step count
    output logic      [6:0] IF_WRITE_ADDR_LOW, // Address for page 0/1 writes
    output logic      [6:0] IF_WRITE_ADDR_HIGH,// Address for page 2/3 writes
    output logic            ALT_ADDR_ACTIVE    // Second address in use
);
    localparam int               REG_COUNT = 4;                  // Mapped registers
    localparam int               IDX_W     = $clog2(REG_COUNT);  // Storage index width
    localparam int               OUT_COUNT = 2;                  // Routed general outputs
    localparam logic [IDX_W-1:0] IDX_PULL  = 2'h0;
    localparam logic [IDX_W-1:0] IDX_ROUTE = 2'h1;
    localparam logic [IDX_W-1:0] IDX_TRIM  = 2'h2;
    localparam logic [IDX_W-1:0] IDX_ALT   = 2'h3;

    logic [7:0]           cfg [REG_COUNT];
    logic [7:0]           pull_cfg;
    logic [7:0]           routing;
    logic [7:0]           role_trim;
    logic [7:0]           alt_addr;
    logic [OUT_COUNT-1:0] routed;
    logic                 sel_level;
    logic                 next_alt_active;
    logic [6:0]           next_base;

    // True for the four mapped offsets; everything else reads zero
    function automatic logic reg_mapped(input logic [8:0] addr);
        case (addr)
            borc_pkg::PULL_CFG_OFFSET,
            borc_pkg::ROUTING_OFFSET,
            borc_pkg::ROLE_TRIM_OFFSET,
            borc_pkg::ALT_ADDR_OFFSET: reg_mapped = 1'h1;
            default:                   reg_mapped = 1'h0;
        endcase
    endfunction

    // Storage index of an offset; only meaningful when mapped
    function automatic logic [IDX_W-1:0] reg_index(input logic [8:0] addr);
        case (addr)
            borc_pkg::ROUTING_OFFSET:   reg_index = IDX_ROUTE;
            borc_pkg::ROLE_TRIM_OFFSET: reg_index = IDX_TRIM;
            borc_pkg::ALT_ADDR_OFFSET:  reg_index = IDX_ALT;
            default:                    reg_index = IDX_PULL;
        endcase
    endfunction

    function automatic logic [7:0] reset_value(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_ROUTE: reset_value = borc_pkg::ROUTING_RESET;
            IDX_TRIM:  reset_value = borc_pkg::ROLE_TRIM_RESET;
            IDX_ALT:   reset_value = borc_pkg::ALT_ADDR_RESET;
            default:   reset_value = borc_pkg::PULL_CFG_RESET;
        endcase
    endfunction

    // Read-only bits of the address register stay zero whatever is written
    function automatic logic [7:0] write_mask(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_ALT: write_mask = borc_pkg::ALT_ADDR_WMASK;
            default: write_mask = 8'hFF;
        endcase
    endfunction

    // Writes to unmapped offsets are dropped
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg[IDX_PULL]  <= reset_value(IDX_PULL);
            cfg[IDX_ROUTE] <= reset_value(IDX_ROUTE);
            cfg[IDX_TRIM]  <= reset_value(IDX_TRIM);
            cfg[IDX_ALT]   <= reset_value(IDX_ALT);
        end else if (REG_WE && reg_mapped(REG_ADDR)) begin
            cfg[reg_index(REG_ADDR)] <= REG_WDATA & write_mask(reg_index(REG_ADDR));
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 8'h00;
        end else if (reg_mapped(REG_ADDR)) begin
            REG_RDATA <= cfg[reg_index(REG_ADDR)];
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    assign pull_cfg  = cfg[IDX_PULL];
    assign routing   = cfg[IDX_ROUTE];
    assign role_trim = cfg[IDX_TRIM];
    assign alt_addr  = cfg[IDX_ALT];

    // One route decoder per general output, told apart by its target code
    generate
        for (genvar k = 0; k < OUT_COUNT; k++) begin : g_route
            borc_route_mux #(
                .TARGET((k == 0) ? borc_pkg::ROUTE_OUT_TWO : borc_pkg::ROUTE_OUT_THREE)
            ) u_mux (
                .a_good_route  (routing[borc_pkg::A_GOOD_LSB +: 2]),
                .b_good_route  (routing[borc_pkg::B_GOOD_LSB +: 2]),
                .a_ready_route (routing[borc_pkg::A_READY_LSB +: 2]),
                .b_ready_route (routing[borc_pkg::B_READY_LSB +: 2]),
                .a_good        (RAIL_A_GOOD),
                .b_good        (RAIL_B_GOOD),
                .a_ready       (RAIL_A_READY),
                .b_ready       (RAIL_B_READY),
                .value         (routed[k])
            );
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            GENERAL_OUTPUT_TWO <= 1'b0;
        end else begin
            GENERAL_OUTPUT_TWO <= routed[0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            GENERAL_OUTPUT_THREE <= 1'b0;
        end else begin
            GENERAL_OUTPUT_THREE <= routed[1];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            INPUT_ZERO_PULLDOWN_EN <= 1'b0;
        end else begin
            INPUT_ZERO_PULLDOWN_EN <= pull_cfg[borc_pkg::PULL_IN0_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SOLO_ROLE_SELECT <= 1'b0;
        end else begin
            SOLO_ROLE_SELECT <= role_trim[borc_pkg::SOLO_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            OSCILLATOR_TRIM <= 3'h0;
        end else begin
            // Oscillator runs at nominal plus trim times step
            OSCILLATOR_TRIM <= role_trim[borc_pkg::TRIM_LSB +: borc_pkg::TRIM_W];
        end
    end

    always_comb begin
        case (alt_addr[borc_pkg::ALT_SEL_LSB +: 2])
            borc_pkg::SEL_IN_ZERO: sel_level = GENERAL_INPUT_ZERO;
            borc_pkg::SEL_IN_ONE:  sel_level = GENERAL_INPUT_ONE;
            borc_pkg::SEL_IN_FOUR: sel_level = GENERAL_INPUT_FOUR;
            default:               sel_level = 1'b0;
        endcase
        next_alt_active = sel_level;
        if (next_alt_active) begin
            if (alt_addr[borc_pkg::ALT_UPPER_LSB +: 4] == borc_pkg::UPPER_UNPROGRAMMED) begin
                next_base = DEFAULT_BASE;
            end else begin
                // Upper nibble of the 8-bit address; 7-bit form drops the R/W bit
                next_base = {alt_addr[borc_pkg::ALT_UPPER_LSB +: 4], 3'h0};
            end
        end else begin
            next_base = PRIMARY_BASE;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ALT_ADDR_ACTIVE <= 1'b0;
        end else begin
            ALT_ADDR_ACTIVE <= next_alt_active;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IF_WRITE_ADDR_LOW  <= PRIMARY_BASE;
            IF_WRITE_ADDR_HIGH <= PRIMARY_BASE + borc_pkg::ADDR_PAGE23_OFF;
        end else begin
            // 8-bit base+0/1 are page 0/1 write/read, base+2/3 page 2/3
            IF_WRITE_ADDR_LOW  <= next_base + borc_pkg::ADDR_PAGE01_OFF;
            IF_WRITE_ADDR_HIGH <= next_base + borc_pkg::ADDR_PAGE23_OFF;
        end
    end
endmodule // borc_regs
`default_nettype wire

// File: rtl/borc_route_mux.sv
// Routes one rail indication set onto one general output
`timescale 1ns/1ps
`default_nettype none
module borc_route_mux #(
    parameter logic [1:0] TARGET = 2'h1  // Route code that selects this output
) (
    input  wire logic [1:0] a_good_route,   // Rail A good route code
    input  wire logic [1:0] b_good_route,   // Rail B good route code
    input  wire logic [1:0] a_ready_route,  // Rail A ready route code
    input  wire logic [1:0] b_ready_route,  // Rail B ready route code
    input  wire logic       a_good,         // Rail A good level
    input  wire logic       b_good,         // Rail B good level
    input  wire logic       a_ready,        // Rail A ready level
    input  wire logic       b_ready,        // Rail B ready level
    output logic            value           // OR of indications routed here
);
    // Reserved code 11 never matches a target, so it routes nowhere
    always_comb begin
        value = ((b_good_route == TARGET) & b_good)
              | ((a_good_route == TARGET) & a_good)
              | ((b_ready_route == TARGET) & b_ready)
              | ((a_ready_route == TARGET) & a_ready);
    end
endmodule // borc_route_mux
`default_nettype wire

// File: tb/borc_host_model.sv
// Host side model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module borc_host_model (
    input  wire logic       CLK,       // Clock
    output logic            REG_WE,    // Write strobe
    output logic      [8:0] REG_ADDR,  // Address
    output logic      [7:0] REG_WDATA, // Write data
    input  wire logic [7:0] REG_RDATA  // Read data
);
    initial begin
        REG_WE = 1'b0;
        REG_ADDR = 9'h000;
        REG_WDATA = 8'h00;
    end
    // Write, then leave time for derived outputs to settle
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge CLK);
        REG_WE = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge CLK);
        REG_WE = 1'b0;
        REG_WDATA = ~d;
        repeat (3) @(negedge CLK);
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        @(negedge CLK);
        d = REG_RDATA;
    endtask
endmodule // borc_host_model
`default_nettype wire

// File: tb/borc_regs_assertions.sv
// Concurrent checks on the routing config register ports
`timescale 1ns/1ps
`default_nettype none
module borc_regs_assertions #(
    parameter logic [6:0] PRIMARY_BASE = 7'h68  // Primary base
) (
    input wire logic       CLK,                    // Clock
    input wire logic       SYS_RST,                // Reset
    input wire logic       REG_WE,                 // Write strobe
    input wire logic [8:0] REG_ADDR,               // Address
    input wire logic [7:0] REG_WDATA,              // Write data
    input wire logic       RAIL_A_GOOD,            // Rail A good
    input wire logic       RAIL_B_GOOD,            // Rail B good
    input wire logic       RAIL_A_READY,           // Rail A ready
    input wire logic       RAIL_B_READY,           // Rail B ready
    input wire logic       GENERAL_OUTPUT_TWO,     // Output two
    input wire logic       GENERAL_OUTPUT_THREE,   // Output three
    input wire logic       INPUT_ZERO_PULLDOWN_EN, // Pull-down
    input wire logic       SOLO_ROLE_SELECT,       // Role
    input wire logic [2:0] OSCILLATOR_TRIM,        // Trim
    input wire logic [6:0] IF_WRITE_ADDR_LOW,      // Page 0/1 address
    input wire logic [6:0] IF_WRITE_ADDR_HIGH,     // Page 2/3 address
    input wire logic       ALT_ADDR_ACTIVE         // Second address used
);
    wire logic wr_pull  = REG_WE && REG_ADDR == borc_pkg::PULL_CFG_OFFSET;
    wire logic wr_route = REG_WE && REG_ADDR == borc_pkg::ROUTING_OFFSET;
    wire logic wr_trim  = REG_WE && REG_ADDR == borc_pkg::ROLE_TRIM_OFFSET;
    wire logic wr_alt   = REG_WE && REG_ADDR == borc_pkg::ALT_ADDR_OFFSET;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence quiet(w);
        !w [*2];
    endsequence
    reset_defaults_a: assert property ($past(SYS_RST) |-> !GENERAL_OUTPUT_TWO &&
        OSCILLATOR_TRIM == 3'h0 && IF_WRITE_ADDR_LOW == PRIMARY_BASE) else $error("bad reset value");
    pull_write_a: assert property (wr_pull ##1 quiet(wr_pull) |=>
        INPUT_ZERO_PULLDOWN_EN == $past(REG_WDATA[0], 3)) else $error("pull-down mismatch");
    role_write_a: assert property (wr_trim ##1 quiet(wr_trim) |=>
        SOLO_ROLE_SELECT == $past(REG_WDATA[7], 3)) else $error("role mismatch");
    trim_write_a: assert property (wr_trim ##1 quiet(wr_trim) |=>
        OSCILLATOR_TRIM == $past(REG_WDATA[2:0], 3)) else $error("trim mismatch");
    route_idle_a: assert property ((wr_route && (REG_WDATA == 8'h00 || REG_WDATA == 8'hFF))
        ##1 quiet(wr_route) |=> !GENERAL_OUTPUT_TWO && !GENERAL_OUTPUT_THREE) else $error("idle route");
    route_two_a: assert property ((wr_route && REG_WDATA == 8'h55) ##1 quiet(wr_route) |=>
        GENERAL_OUTPUT_TWO == $past(RAIL_A_GOOD | RAIL_B_GOOD | RAIL_A_READY | RAIL_B_READY)
        && !GENERAL_OUTPUT_THREE) else $error("route to two wrong");
    addr_pair_a: assert property (IF_WRITE_ADDR_HIGH == IF_WRITE_ADDR_LOW + 7'h01)
        else $error("page address pair wrong");
    primary_idle_a: assert property (!ALT_ADDR_ACTIVE && !$past(ALT_ADDR_ACTIVE) |->
        IF_WRITE_ADDR_LOW == PRIMARY_BASE) else $error("primary address lost");
    sel_none_a: assert property ((wr_alt && REG_WDATA[1:0] == 2'h0) ##1 quiet(wr_alt) |=>
        !ALT_ADDR_ACTIVE) else $error("select none active");
endmodule // borc_regs_assertions
bind borc_regs borc_regs_assertions #(.PRIMARY_BASE(PRIMARY_BASE)) chk_u (.CLK, .SYS_RST,
    .REG_WE, .REG_ADDR, .REG_WDATA, .RAIL_A_GOOD, .RAIL_B_GOOD, .RAIL_A_READY, .RAIL_B_READY,
    .GENERAL_OUTPUT_TWO, .GENERAL_OUTPUT_THREE, .INPUT_ZERO_PULLDOWN_EN, .SOLO_ROLE_SELECT,
    .OSCILLATOR_TRIM, .IF_WRITE_ADDR_LOW, .IF_WRITE_ADDR_HIGH, .ALT_ADDR_ACTIVE);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the routing config registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       CLK, SYS_RST, we;
    logic [8:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [3:0] rail;
    logic [2:0] gin;
    logic       o2, o3, pd, solo, act;
    logic [2:0] trim;
    logic [6:0] lo, hi, el;
    int         num_errors, tests_run;
    borc_regs #(.PRIMARY_BASE(7'h30), .DEFAULT_BASE(7'h50)) dut_u (.CLK(CLK), .SYS_RST(SYS_RST),
        .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .RAIL_A_READY(rail[0]), .RAIL_B_READY(rail[1]), .RAIL_A_GOOD(rail[2]),
        .RAIL_B_GOOD(rail[3]), .GENERAL_INPUT_ZERO(gin[0]), .GENERAL_INPUT_ONE(gin[1]),
        .GENERAL_INPUT_FOUR(gin[2]), .GENERAL_OUTPUT_TWO(o2), .GENERAL_OUTPUT_THREE(o3),
        .INPUT_ZERO_PULLDOWN_EN(pd), .SOLO_ROLE_SELECT(solo), .OSCILLATOR_TRIM(trim),
        .IF_WRITE_ADDR_LOW(lo), .IF_WRITE_ADDR_HIGH(hi), .ALT_ADDR_ACTIVE(act));
    borc_host_model host_u (.CLK(CLK), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    initial begin
        #2ms;
        num_errors++;
        conclude();
    end
    initial begin
        num_errors = 0;
        tests_run = 0;
        rail = 4'h0;
        gin = 3'h0;
        SYS_RST = 1'b1;
        repeat (12) @(negedge CLK);
        SYS_RST = 1'b0;
        host_u.wr(9'h149, 8'hFF);
        for (int a = 9'h145; a <= 9'h149; a++) begin
            host_u.rd(9'(a), d);
            check(d, 8'h00);
        end
        host_u.wr(9'h145, 8'h01);
        check({7'h00, pd}, 8'h01);
        host_u.wr(9'h145, 8'h00);
        check({7'h00, pd}, 8'h00);
        for (int f = 0; f < 4; f++) for (int c = 0; c < 4; c++) begin
            rail = 4'(1 << f);
            host_u.wr(9'h146, 8'(c << (2 * f)));
            check({6'h00, o3, o2}, {6'h00, c == 2, c == 1});
            host_u.rd(9'h146, d);
            check(d, 8'(c << (2 * f)));
        end
        rail = 4'hF;
        host_u.wr(9'h146, 8'h55);
        check({6'h00, o3, o2}, 8'h01);
        host_u.wr(9'h146, 8'hAA);
        check({6'h00, o3, o2}, 8'h02);
        host_u.wr(9'h146, 8'hFF);
        check({6'h00, o3, o2}, 8'h00);
        for (int t = 0; t < 8; t++) begin
            host_u.wr(9'h147, {t[0], 4'h0, 3'(t)});
            check({solo, 4'h0, trim}, {t[0], 4'h0, 3'(t)});
        end
        host_u.wr(9'h148, 8'hDF);
        host_u.rd(9'h148, d);
        check(d, 8'hD3);
        for (int s = 0; s < 4; s++) begin
            host_u.wr(9'h148, 8'hD0 | 8'(s));
            for (int g = 0; g < 8; g++) begin
                gin = 3'(g);
                repeat (2) @(negedge CLK);
                el = (s != 0 && g[s - 1]) ? 7'h68 : 7'h30;
                check({act, lo}, {s != 0 && g[s - 1], el});
                check({1'b0, hi}, {1'b0, el + 7'h01});
            end
        end
        host_u.wr(9'h148, 8'h01);
        gin = 3'h1;
        repeat (2) @(negedge CLK);
        check({1'b0, lo}, 8'h50);
        check({1'b0, hi}, 8'h51);
        conclude();
    end
endmodule // testbench
`default_nettype wire
